// [pkg/pi_smo_pkg.sv]
/*
  Shared constants and carriers for the regulator and observer word bank.
  Assumes an 8-bit special function register space and a page selector
  that lives outside this block.
*/
package pi_smo_pkg;

  localparam logic [7:0] ADDR_INTEGRAL_LO = 8'h9d;
  localparam logic [7:0] ADDR_INTEGRAL_HI = 8'h9e;
  localparam logic [7:0] ADDR_OUTPUT_LO = 8'hac;
  localparam logic [7:0] ADDR_OUTPUT_HI = 8'had;
  localparam logic [7:0] ADDR_FEEDBACK_LO = 8'hae;
  localparam logic [7:0] ADDR_FEEDBACK_HI = 8'haf;
  localparam logic [7:0] ADDR_OBS1_LO = 8'hbb;
  localparam logic [7:0] ADDR_OBS1_HI = 8'hbc;
  localparam logic [7:0] ADDR_OBS2_LO = 8'hbd;
  localparam logic [7:0] ADDR_OBS2_HI = 8'hbe;
  localparam logic [7:0] ADDR_TRACK = 8'hd7;

  localparam int LOOP_PAGES = 5;
  localparam int OBS1_PAGES = 6;
  localparam int OBS2_PAGES = 5;

  // Observer word 1 pages
  localparam int PG_PARAM_G = 0;
  localparam int PG_OBS_GAIN = 1;
  localparam int PG_ANGLE_BASE = 2;
  localparam int PG_ZCORR = 3;
  localparam int PG_EST_ANGLE = 4;
  localparam int PG_BANGBANG = 5;
  // Observer word 2 pages
  localparam int PG_PARAM_F = 0;
  localparam int PG_FILTER = 1;
  localparam int PG_ANGLE_SHIFT = 2;
  localparam int PG_MAX_SLIDE = 3;
  localparam int PG_SPEED = 4;

  localparam logic [15:0] RST_LOOP_WORD = 16'h0000;
  localparam logic [15:0] RST_PARAM_G = 16'h7fff;
  localparam logic [15:0] RST_OBS_GAIN = 16'h3e80;
  localparam logic [15:0] RST_ANGLE_BASE = 16'h0b2f;
  localparam logic [15:0] RST_ZCORR = 16'h7fff;
  localparam logic [15:0] RST_EST_ANGLE = 16'h0000;
  localparam logic [15:0] RST_BANGBANG = 16'h7fff;
  localparam logic [15:0] RST_PARAM_F = 16'h7fff;
  localparam logic [15:0] RST_FILTER = 16'h0064;
  localparam logic [15:0] RST_ANGLE_SHIFT = 16'h0000;
  localparam logic [15:0] RST_MAX_SLIDE = 16'h7fff;
  localparam logic [15:0] RST_SPEED = 16'h0000;
  localparam logic [7:0] RST_TRACK = 8'h00;

  localparam logic [31:0] ZCORR_FULL_SCALE = 32'd32767;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Bit order matches the tracking mode register, bit 7 first
  typedef struct packed {
    logic qcur_track_manual;
    logic qcur_track_on;
    logic dcur_track_manual;
    logic dcur_track_on;
    logic spd_track_manual;
    logic spd_track_on;
    logic angle_loop_track_manual;
    logic angle_loop_track_on;
  } track_t;

  typedef struct packed {
    logic [15:0] observer_param_g;
    logic [15:0] observer_gain;
    logic [15:0] angle_base;
    logic [15:0] zgain_correction;
    logic [15:0] bangbang_zgain;
    logic [15:0] observer_param_f;
    logic [15:0] observer_filter_coef;
    logic [15:0] angle_shift;
    logic [15:0] max_slide_error;
  } obs_param_t;

  typedef struct packed {
    logic angle_vld;
    logic [15:0] estimated_angle;
    logic speed_vld;
    logic [15:0] measured_speed;
  } obs_est_t;

endpackage

// [rtl/banked_word.sv]
/*
  One paged 16-bit word: a register per page, written a byte at a time
  at the page the selector names, and loadable by hardware per page.
  Assumes selector and strobes are on the same clock and reset.
*/
`timescale 1ns/100ps
module banked_word #(
  parameter int PAGES = 5,
  parameter logic [PAGES*16-1:0] RESET_VALS = '0,
  parameter logic [PAGES-1:0] RO_MASK = '0
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i,
  input wire logic [2:0] page_i,
  input wire logic [7:0] wdata_i,
  input wire logic [PAGES-1:0] ld_i,
  input wire logic [PAGES-1:0][15:0] ld_data_i,
  output logic [PAGES-1:0][15:0] words_o,
  output logic [15:0] rdata_o
);

  if (PAGES < 1 || PAGES > 8) begin : g_bad_pages
    $error("banked_word: PAGES must be 1 to 8");
  end

  wire page_ok = int'(page_i) < PAGES;
  assign rdata_o = page_ok ? words_o[page_i] : 16'h0000;

  for (genvar p = 0; p < PAGES; p++) begin : g_page
    // Only the addressed page takes bus writes; a read-only page ignores the bus
    wire hit = (int'(page_i) == p) && !RO_MASK[p];
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        words_o[p] <= RESET_VALS[p*16 +: 16];
      end else if (ld_i[p]) begin
        words_o[p] <= ld_data_i[p];
      end else if (hit && wr_lo_i) begin
        words_o[p][7:0] <= wdata_i;
      end else if (hit && wr_hi_i) begin
        words_o[p][15:8] <= wdata_i;
      end
    end
  end

endmodule

// [rtl/pi_smo_param_registers.sv]
/*
  Paged register bank for the five regulator loops and the sliding-mode
  observer, seen from the CPU special function register space.
  Assumes the page selector register and the observer datapath sit
  outside, on the same clock; only the reset arrives asynchronously.
*/
`timescale 1ns/100ps
module pi_smo_param_registers (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire pi_smo_pkg::sfr_req_t sfr_req_i,
  input wire logic [2:0] page_selector_i,
  input wire pi_smo_pkg::obs_est_t obs_est_i,
  input wire logic [15:0] zgain_i,
  output logic [7:0] sfr_rdata_o,
  output logic [pi_smo_pkg::LOOP_PAGES-1:0][15:0] loop_integral_o,
  output logic [pi_smo_pkg::LOOP_PAGES-1:0][15:0] loop_output_o,
  output logic [pi_smo_pkg::LOOP_PAGES-1:0][15:0] loop_feedback_o,
  output pi_smo_pkg::track_t tracking_o,
  output pi_smo_pkg::obs_param_t obs_param_o,
  output logic [31:0] slide_gain_first_o,
  output logic [15:0] slide_gain_second_o,
  output logic [15:0] zgain_scaled_o
);

  localparam int LP = pi_smo_pkg::LOOP_PAGES;
  localparam int O1 = pi_smo_pkg::OBS1_PAGES;
  localparam int O2 = pi_smo_pkg::OBS2_PAGES;

  // Reset release through two flops so all state leaves reset together
  logic [1:0] rst_pipe_q;
  logic rst_n;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_pipe_q <= 2'b00;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_q[1];

  // Address decode
  wire wr = sfr_req_i.wr;
  wire [7:0] addr = sfr_req_i.addr;
  wire [7:0] wdata = sfr_req_i.wdata;
  wire hit_int_lo = addr == pi_smo_pkg::ADDR_INTEGRAL_LO;
  wire hit_int_hi = addr == pi_smo_pkg::ADDR_INTEGRAL_HI;
  wire hit_out_lo = addr == pi_smo_pkg::ADDR_OUTPUT_LO;
  wire hit_out_hi = addr == pi_smo_pkg::ADDR_OUTPUT_HI;
  wire hit_fb_lo = addr == pi_smo_pkg::ADDR_FEEDBACK_LO;
  wire hit_fb_hi = addr == pi_smo_pkg::ADDR_FEEDBACK_HI;
  wire hit_o1_lo = addr == pi_smo_pkg::ADDR_OBS1_LO;
  wire hit_o1_hi = addr == pi_smo_pkg::ADDR_OBS1_HI;
  wire hit_o2_lo = addr == pi_smo_pkg::ADDR_OBS2_LO;
  wire hit_o2_hi = addr == pi_smo_pkg::ADDR_OBS2_HI;
  wire hit_track = addr == pi_smo_pkg::ADDR_TRACK;

  logic [15:0] int_word, out_word, fb_word, o1_word, o2_word;
  logic [O1-1:0][15:0] o1_words;
  logic [O2-1:0][15:0] o2_words;

  // Loop words carry no hardware load here; the regulators read them
  banked_word #(
    .PAGES(LP),
    .RESET_VALS({LP{pi_smo_pkg::RST_LOOP_WORD}})
  ) u_integral (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .wr_lo_i(wr && hit_int_lo),
    .wr_hi_i(wr && hit_int_hi),
    .page_i(page_selector_i),
    .wdata_i(wdata),
    .ld_i('0),
    .ld_data_i('0),
    .words_o(loop_integral_o),
    .rdata_o(int_word)
  );

  banked_word #(
    .PAGES(LP),
    .RESET_VALS({LP{pi_smo_pkg::RST_LOOP_WORD}})
  ) u_output (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .wr_lo_i(wr && hit_out_lo),
    .wr_hi_i(wr && hit_out_hi),
    .page_i(page_selector_i),
    .wdata_i(wdata),
    .ld_i('0),
    .ld_data_i('0),
    .words_o(loop_output_o),
    .rdata_o(out_word)
  );

  banked_word #(
    .PAGES(LP),
    .RESET_VALS({LP{pi_smo_pkg::RST_LOOP_WORD}})
  ) u_feedback (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .wr_lo_i(wr && hit_fb_lo),
    .wr_hi_i(wr && hit_fb_hi),
    .page_i(page_selector_i),
    .wdata_i(wdata),
    .ld_i('0),
    .ld_data_i('0),
    .words_o(loop_feedback_o),
    .rdata_o(fb_word)
  );

  // Estimates enter only through the load port; the bus cannot touch them
  logic [O1-1:0] o1_ld;
  logic [O1-1:0][15:0] o1_ld_data;
  logic [O2-1:0] o2_ld;
  logic [O2-1:0][15:0] o2_ld_data;
  always_comb begin
    o1_ld = '0;
    o1_ld_data = '0;
    o2_ld = '0;
    o2_ld_data = '0;
    o1_ld[pi_smo_pkg::PG_EST_ANGLE] = obs_est_i.angle_vld;
    o1_ld_data[pi_smo_pkg::PG_EST_ANGLE] = obs_est_i.estimated_angle;
    o2_ld[pi_smo_pkg::PG_SPEED] = obs_est_i.speed_vld;
    o2_ld_data[pi_smo_pkg::PG_SPEED] = obs_est_i.measured_speed;
  end

  banked_word #(
    .PAGES(O1),
    .RESET_VALS({pi_smo_pkg::RST_BANGBANG, pi_smo_pkg::RST_EST_ANGLE,
                 pi_smo_pkg::RST_ZCORR, pi_smo_pkg::RST_ANGLE_BASE,
                 pi_smo_pkg::RST_OBS_GAIN, pi_smo_pkg::RST_PARAM_G}),
    .RO_MASK(6'h10)
  ) u_obs1 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .wr_lo_i(wr && hit_o1_lo),
    .wr_hi_i(wr && hit_o1_hi),
    .page_i(page_selector_i),
    .wdata_i(wdata),
    .ld_i(o1_ld),
    .ld_data_i(o1_ld_data),
    .words_o(o1_words),
    .rdata_o(o1_word)
  );

  banked_word #(
    .PAGES(O2),
    .RESET_VALS({pi_smo_pkg::RST_SPEED, pi_smo_pkg::RST_MAX_SLIDE,
                 pi_smo_pkg::RST_ANGLE_SHIFT, pi_smo_pkg::RST_FILTER,
                 pi_smo_pkg::RST_PARAM_F}),
    .RO_MASK(5'h10)
  ) u_obs2 (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .wr_lo_i(wr && hit_o2_lo),
    .wr_hi_i(wr && hit_o2_hi),
    .page_i(page_selector_i),
    .wdata_i(wdata),
    .ld_i(o2_ld),
    .ld_data_i(o2_ld_data),
    .words_o(o2_words),
    .rdata_o(o2_word)
  );

  // Tracking mode register
  pi_smo_pkg::track_t track_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      track_q <= pi_smo_pkg::RST_TRACK;
    end else if (wr && hit_track) begin
      track_q <= pi_smo_pkg::track_t'(wdata);
    end
  end
  assign tracking_o = track_q;

  assign obs_param_o.observer_param_g = o1_words[pi_smo_pkg::PG_PARAM_G];
  assign obs_param_o.observer_gain = o1_words[pi_smo_pkg::PG_OBS_GAIN];
  assign obs_param_o.angle_base = o1_words[pi_smo_pkg::PG_ANGLE_BASE];
  assign obs_param_o.zgain_correction = o1_words[pi_smo_pkg::PG_ZCORR];
  assign obs_param_o.bangbang_zgain = o1_words[pi_smo_pkg::PG_BANGBANG];
  assign obs_param_o.observer_param_f = o2_words[pi_smo_pkg::PG_PARAM_F];
  assign obs_param_o.observer_filter_coef = o2_words[pi_smo_pkg::PG_FILTER];
  assign obs_param_o.angle_shift = o2_words[pi_smo_pkg::PG_ANGLE_SHIFT];
  assign obs_param_o.max_slide_error = o2_words[pi_smo_pkg::PG_MAX_SLIDE];

  // Read path: unmapped addresses and absent pages read as zero
  wire [7:0] rd_byte =
    hit_int_lo ? int_word[7:0] : hit_int_hi ? int_word[15:8] :
    hit_out_lo ? out_word[7:0] : hit_out_hi ? out_word[15:8] :
    hit_fb_lo ? fb_word[7:0] : hit_fb_hi ? fb_word[15:8] :
    hit_o1_lo ? o1_word[7:0] : hit_o1_hi ? o1_word[15:8] :
    hit_o2_lo ? o2_word[7:0] : hit_o2_hi ? o2_word[15:8] :
    hit_track ? track_q : 8'h00;

  logic [7:0] rdata_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (sfr_req_i.rd) begin
      rdata_q <= rd_byte;
    end
  end
  assign sfr_rdata_o = rdata_q;

  // Gain arithmetic, registered to keep the multipliers off the bus path
  wire [31:0] gain_prod = {16'h0000, obs_param_o.observer_gain} *
                          {16'h0000, obs_param_o.max_slide_error};
  wire [31:0] zcorr_prod = {16'h0000, zgain_i} *
                           {16'h0000, obs_param_o.zgain_correction};
  wire [31:0] zcorr_quot = zcorr_prod / pi_smo_pkg::ZCORR_FULL_SCALE;
  // Corrections above full scale could overflow; saturate instead of wrap
  wire [15:0] zgain_sat = (zcorr_quot[31:16] != 16'h0000) ?
                          16'hffff : zcorr_quot[15:0];

  logic [31:0] slide1_q;
  logic [15:0] slide2_q, zgain_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      slide1_q <= 32'h0000_0000;
      slide2_q <= 16'h0000;
      zgain_q <= 16'h0000;
    end else begin
      slide1_q <= gain_prod;
      slide2_q <= obs_param_o.bangbang_zgain;
      zgain_q <= zgain_sat;
    end
  end
  assign slide_gain_first_o = slide1_q;
  assign slide_gain_second_o = slide2_q;
  assign zgain_scaled_o = zgain_q;

  // Checks
  wire pg_loop = int'(page_selector_i) < LP;

  sequence wr_int_lo_s;
    wr && hit_int_lo && pg_loop;
  endsequence

  sequence wr_int_hi_s;
    wr && hit_int_hi && pg_loop;
  endsequence

  integ_low_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    wr_int_lo_s |=> loop_integral_o[$past(page_selector_i)][7:0] ==
                    $past(wdata))
    else $error("integral low byte not stored");

  integ_high_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    wr_int_hi_s |=> loop_integral_o[$past(page_selector_i)][15:8] ==
                    $past(wdata))
    else $error("integral high byte not stored");

  output_write_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    wr && hit_out_hi && pg_loop |=>
      loop_output_o[$past(page_selector_i)][15:8] == $past(wdata))
    else $error("output word not stored");

  fback_write_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    wr && hit_fb_lo && pg_loop |=>
      loop_feedback_o[$past(page_selector_i)][7:0] == $past(wdata))
    else $error("feedback word not stored");

  track_write_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    wr && hit_track |=> tracking_o.qcur_track_manual == $past(wdata[7])
                        && tracking_o.angle_loop_track_on == $past(wdata[0]))
    else $error("tracking bits misplaced");

  track_read_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    sfr_req_i.rd && hit_track && !wr |=> sfr_rdata_o == $past(track_q))
    else $error("tracking register read back wrong");

  angle_ro_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    wr && (hit_o1_lo || hit_o1_hi) && !obs_est_i.angle_vld &&
    int'(page_selector_i) == pi_smo_pkg::PG_EST_ANGLE |=>
      $stable(o1_words[pi_smo_pkg::PG_EST_ANGLE]))
    else $error("estimated angle written by bus");

  speed_load_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    obs_est_i.speed_vld |=>
      o2_words[pi_smo_pkg::PG_SPEED] == $past(obs_est_i.measured_speed))
    else $error("speed estimate not captured");

  // Sampled rst_n keeps the release edge out; outputs still show reset there
  slide_first_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    rst_n && $stable(obs_param_o.observer_gain) &&
    $stable(obs_param_o.max_slide_error)
    |=> slide_gain_first_o == $past(obs_param_o.observer_gain) *
                              $past(obs_param_o.max_slide_error))
    else $error("first sliding gain wrong");

  slide_second_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    rst_n |=> slide_gain_second_o == $past(o1_words[pi_smo_pkg::PG_BANGBANG]))
    else $error("second sliding gain wrong");

  other_page_a: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n)
    wr && hit_int_lo && page_selector_i != 3'h0 |=>
      $stable(loop_integral_o[0]))
    else $error("write leaked to another page");

endmodule

// [verification/test_pi_smo_param_registers.sv]
/*
  Self-checking bench for the paged regulator and observer word bank.
  Assumes the bench drives the page selector, estimates and raw Z gain.
*/
`timescale 1ns/100ps
module test_pi_smo_param_registers;
  logic ref_clk_i;
  logic reset_n_i;
  pi_smo_pkg::sfr_req_t sfr_req_i;
  logic [2:0] page_selector_i;
  pi_smo_pkg::obs_est_t obs_est_i;
  logic [15:0] zgain_i;
  logic [7:0] sfr_rdata_o;
  logic [pi_smo_pkg::LOOP_PAGES-1:0][15:0] loop_integral_o;
  logic [pi_smo_pkg::LOOP_PAGES-1:0][15:0] loop_output_o;
  logic [pi_smo_pkg::LOOP_PAGES-1:0][15:0] loop_feedback_o;
  pi_smo_pkg::track_t tracking_o;
  pi_smo_pkg::obs_param_t obs_param_o;
  logic [31:0] slide_gain_first_o;
  logic [15:0] slide_gain_second_o;
  logic [15:0] zgain_scaled_o;
  int fail_count = 0;
  int cmp_count = 0;
  logic [15:0] obs1_rst [6] = '{16'h7fff, 16'h3e80, 16'h0b2f, 16'h7fff,
                                16'h0000, 16'h7fff};
  logic [15:0] obs2_rst [5] = '{16'h7fff, 16'h0064, 16'h0000, 16'h7fff,
                                16'h0000};
  logic [7:0] loop_lo [3] = '{8'h9d, 8'hac, 8'hae};

  pi_smo_param_registers i_dut (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .sfr_req_i(sfr_req_i),
    .page_selector_i(page_selector_i),
    .obs_est_i(obs_est_i),
    .zgain_i(zgain_i),
    .sfr_rdata_o(sfr_rdata_o),
    .loop_integral_o(loop_integral_o),
    .loop_output_o(loop_output_o),
    .loop_feedback_o(loop_feedback_o),
    .tracking_o(tracking_o),
    .obs_param_o(obs_param_o),
    .slide_gain_first_o(slide_gain_first_o),
    .slide_gain_second_o(slide_gain_second_o),
    .zgain_scaled_o(zgain_scaled_o)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Strobe is raised on one edge and lowered on the next, never both at once
  task automatic wr8(input logic [7:0] a, input logic [2:0] p,
                     input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    page_selector_i <= p;
    @(posedge ref_clk_i);
    sfr_req_i.wr <= 1'b0;
    @(negedge ref_clk_i);
  endtask

  task automatic rd8(input logic [7:0] a, input logic [2:0] p,
                     output logic [7:0] d);
    @(posedge ref_clk_i);
    sfr_req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    page_selector_i <= p;
    @(posedge ref_clk_i);
    sfr_req_i.rd <= 1'b0;
    @(negedge ref_clk_i);
    d = sfr_rdata_o;
  endtask

  task automatic wr16(input logic [7:0] a, input logic [2:0] p,
                      input logic [15:0] v);
    wr8(a, p, v[7:0]);
    wr8(a + 8'h01, p, v[15:8]);
  endtask

  task automatic chk16(input logic [7:0] a, input logic [2:0] p,
                       input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    rd8(a, p, lo);
    rd8(a + 8'h01, p, hi);
    check_val({hi, lo}, exp);
  endtask

  // Hang guard: the run is short, so a generous bound is enough
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    print_verdict();
  end

  initial begin
    logic [7:0] b;
    reset_n_i = 1'b0;
    sfr_req_i = '0;
    page_selector_i = 3'h0;
    obs_est_i = '0;
    zgain_i = 16'h1000;
    repeat (16) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    for (int p = 0; p < 5; p++) begin
      chk16(8'h9d, 3'(p), 16'h0000);
      chk16(8'hac, 3'(p), 16'h0000);
      chk16(8'hae, 3'(p), 16'h0000);
    end
    for (int p = 0; p < 6; p++) begin
      chk16(8'hbb, 3'(p), obs1_rst[p]);
    end
    for (int p = 0; p < 5; p++) begin
      chk16(8'hbd, 3'(p), obs2_rst[p]);
    end
    rd8(8'hd7, 3'h0, b);
    check_val(b, 8'h00);
    // Distinct value per word and page exposes any crossed bank
    foreach (loop_lo[i]) begin
      for (int p = 0; p < 5; p++) begin
        wr16(loop_lo[i], 3'(p), {loop_lo[i], 5'h00, 3'(p)});
      end
    end
    foreach (loop_lo[i]) begin
      for (int p = 0; p < 5; p++) begin
        chk16(loop_lo[i], 3'(p), {loop_lo[i], 5'h00, 3'(p)});
      end
    end
    for (int p = 0; p < 5; p++) begin
      check_val(loop_integral_o[p], {8'h9d, 5'h00, 3'(p)});
      check_val(loop_output_o[p], {8'hac, 5'h00, 3'(p)});
      check_val(loop_feedback_o[p], {8'hae, 5'h00, 3'(p)});
    end
    wr8(8'h9e, 3'h1, 8'h5a);
    check_val(loop_integral_o[1], 16'h5a01);
    wr16(8'h9d, 3'h5, 16'hdead);
    chk16(8'h9d, 3'h5, 16'h0000);
    check_val(loop_integral_o[4], 16'h9d04);
    wr8(8'h9f, 3'h0, 8'h77);
    rd8(8'h9f, 3'h0, b);
    check_val(b, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr8(8'hd7, 3'h0, 8'h01 << i);
      check_val(tracking_o, 8'h01 << i);
      rd8(8'hd7, 3'h0, b);
      check_val(b, 8'h01 << i);
    end
    check_val(tracking_o.qcur_track_manual, 1'b1);
    wr8(8'hd7, 3'h0, 8'h55);
    check_val(tracking_o.angle_loop_track_on, 1'b1);
    check_val(tracking_o.spd_track_manual, 1'b0);
    check_val(tracking_o.dcur_track_on, 1'b1);
    // Estimates: bus writes are dropped, hardware loads land
    wr16(8'hbb, 3'h4, 16'hbeef);
    chk16(8'hbb, 3'h4, 16'h0000);
    wr16(8'hbd, 3'h4, 16'hbeef);
    chk16(8'hbd, 3'h4, 16'h0000);
    @(posedge ref_clk_i);
    obs_est_i <= '{1'b1, 16'h1234, 1'b1, 16'h4321};
    @(posedge ref_clk_i);
    obs_est_i <= '{1'b0, 16'h0000, 1'b0, 16'h0000};
    chk16(8'hbb, 3'h4, 16'h1234);
    chk16(8'hbd, 3'h4, 16'h4321);
    wr16(8'hbb, 3'h0, 16'h1111);
    wr16(8'hbb, 3'h2, 16'h2222);
    wr16(8'hbd, 3'h0, 16'h3333);
    wr16(8'hbd, 3'h1, 16'h4444);
    wr16(8'hbd, 3'h2, 16'h5555);
    check_val(obs_param_o.observer_param_g, 16'h1111);
    check_val(obs_param_o.angle_base, 16'h2222);
    check_val(obs_param_o.observer_param_f, 16'h3333);
    check_val(obs_param_o.observer_filter_coef, 16'h4444);
    check_val(obs_param_o.angle_shift, 16'h5555);
    chk16(8'hbd, 3'h2, 16'h5555);
    wr16(8'hbb, 3'h1, 16'h0123);
    wr16(8'hbd, 3'h3, 16'h0045);
    wr16(8'hbb, 3'h5, 16'h2468);
    wr16(8'hbb, 3'h3, 16'h4000);
    repeat (2) @(negedge ref_clk_i);
    check_val(obs_param_o.max_slide_error, 16'h0045);
    check_val(obs_param_o.observer_gain, 16'h0123);
    check_val(obs_param_o.zgain_correction, 16'h4000);
    check_val(obs_param_o.bangbang_zgain, 16'h2468);
    check_val(slide_gain_first_o, 32'h0123 * 32'h0045);
    check_val(slide_gain_second_o, 16'h2468);
    check_val(zgain_scaled_o, (32'h1000 * 32'h4000) / 32'd32767);
    @(posedge ref_clk_i);
    zgain_i <= 16'hffff;
    wr16(8'hbb, 3'h3, 16'hffff);
    repeat (2) @(negedge ref_clk_i);
    check_val(zgain_scaled_o, 16'hffff);
    print_verdict();
  end
endmodule
